// ==== fgl_loop_config.sv ====
// loop configuration register, speed pulse output gating and stop action decode
//
// Summary of operation
// - bit clear continuous, set discontinuous modulation
// - phase select zero pulses open and closed
// - phase select one pulses closed loop only
// - phase select two open loop first try
// - divider codes 0,1 by one, else code
// - stop policy clear pulses while driving
// - stop policy set stops below bemf threshold
// - threshold codes map 1..30 mV, 6-7 reserved
// - early stop brake chooses hi-z or low-side
//
// ************************************************************
// behaviour notes
// ************************************************************
// the configuration word sits at the first register address
// only bits 14 down to 0 are stored, upper bits read as zero
// writes merge byte lanes under the write strobes
// a write to any other address answers slverr and stores nothing
// reads of unmapped addresses answer slverr with zero data
// the second address returns a live state word:
//    bits 1..0  motor phase from the commutation engine
//    bit 2      phase select holds the undefined code
//    bit 3      threshold field holds a reserved code
//    bit 4      early stop chose high impedance
//    bit 5      early stop chose low-side braking
//    bit 6      speed pulses currently allowed
//    bit 7      pulses halted by low back-emf
// write address and data are taken in either order
// the write answer follows one cycle after both are held
// the read answer follows one cycle after the address is taken
// only one write and one read are open at a time
// speed pulses appear two cycles after the raw engine event
// the divider counts only gated events, so a closed gate
//    leaves a partial count that carries into the next run
// a divider change mid-count takes effect at the next compare
// reserved threshold codes clamp to the widest window
// the undefined phase select code blocks all pulses
// the back-emf stop latch clears when drive resumes in open loop
// early stop outputs are levels, valid only while requested
//
module fgl_loop_config (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 srst,
   // axi4-lite write address
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   // axi4-lite read data
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // motor engine status
   input  wire fgl_pkg::fgl_phase_t  motor_phase,
   input  wire logic                 motor_driven,
   input  wire logic                 first_try,
   input  wire logic                 elec_pulse,
   input  wire logic [7:0]           bemf_mv,
   input  wire logic                 recirc_stop_req,
   // decoded configuration to engine
   output fgl_pkg::fgl_cfg_t         cfg,
   output logic [7:0]                bemf_thr_mv,
   output logic                      stop_hiz,
   output logic                      stop_low_brake,
   // speed pulse pin
   output logic                      speed_pulse_output
);

   // ************************************************************
   // storage
   // ************************************************************
   logic [31:0] loop_tuning_config_one;  // software configuration word
   logic        aw_held;                 // write address captured
   logic        w_held;                  // write data captured
   logic [7:0]  aw_addr;                 // captured write address
   logic [31:0] w_data;                  // captured write data
   logic [3:0]  w_strb;                  // captured strobes
   logic        pulse_gate;              // pulses allowed now
   logic        bemf_stopped;            // pulses halted by low bemf
   logic        divided_pulse;           // divider output
   logic [31:0] status_word;             // live state readback
   logic [31:0] next_cfg_word;           // merged write value

   // ************************************************************
   // field decode
   // ************************************************************
   // modulation select bit
   assign cfg.discontinuous_svm        = loop_tuning_config_one[fgl_pkg::MOD_SEL_POS];
   assign cfg.speed_pulse_phase_select = loop_tuning_config_one[fgl_pkg::PHASE_SEL_LSB +: 2];
   assign cfg.speed_pulse_divider      = loop_tuning_config_one[fgl_pkg::DIVIDER_LSB +: 4];
   assign cfg.speed_pulse_stop_policy  = loop_tuning_config_one[fgl_pkg::STOP_POLICY_POS];
   assign cfg.back_emf_stop_threshold  = loop_tuning_config_one[fgl_pkg::BEMF_THR_LSB +: 3];
   assign cfg.surge_guard_enable       = loop_tuning_config_one[fgl_pkg::SURGE_POS];
   assign cfg.deadtime_comp_enable     = loop_tuning_config_one[fgl_pkg::DEADTIME_POS];
   assign cfg.velocity_loop_off        = loop_tuning_config_one[fgl_pkg::VLOOP_OFF_POS];
   assign cfg.early_stop_brake_select  = loop_tuning_config_one[fgl_pkg::EARLY_BRAKE_POS];

   // threshold code to millivolts
   always_comb begin
      case (cfg.back_emf_stop_threshold)
         3'h0:    bemf_thr_mv = fgl_pkg::BEMF_MV_0;
         3'h1:    bemf_thr_mv = fgl_pkg::BEMF_MV_1;
         3'h2:    bemf_thr_mv = fgl_pkg::BEMF_MV_2;
         3'h3:    bemf_thr_mv = fgl_pkg::BEMF_MV_3;
         3'h4:    bemf_thr_mv = fgl_pkg::BEMF_MV_4;
         3'h5:    bemf_thr_mv = fgl_pkg::BEMF_MV_5;
         default: bemf_thr_mv = fgl_pkg::BEMF_MV_5;  // reserved: clamp to widest
      endcase
   end

   // ************************************************************
   // speed pulse phase gating
   // ************************************************************
   always_comb begin
      case (cfg.speed_pulse_phase_select)
         fgl_pkg::PHASE_ALWAYS:
            pulse_gate = (motor_phase == fgl_pkg::FGL_OPEN) || (motor_phase == fgl_pkg::FGL_CLOSED);
         fgl_pkg::PHASE_CLOSED:
            pulse_gate = (motor_phase == fgl_pkg::FGL_CLOSED);
         fgl_pkg::PHASE_FIRST_TRY:
            pulse_gate = (motor_phase == fgl_pkg::FGL_CLOSED) ||
                         ((motor_phase == fgl_pkg::FGL_OPEN) && first_try);
         default:
            pulse_gate = 1'b0;  // undefined code: no pulses
      endcase
   end

   // ************************************************************
   // bemf stop latch
   // ************************************************************
   // set once bemf falls below threshold, cleared when drive restarts in open loop
   always_ff @(posedge clk) begin
      if (srst) begin
         bemf_stopped <= 1'b0;
      end else if (!cfg.speed_pulse_stop_policy) begin
         bemf_stopped <= 1'b0;
      end else if (bemf_mv < bemf_thr_mv) begin
         bemf_stopped <= 1'b1;
      end else if (motor_driven && motor_phase == fgl_pkg::FGL_OPEN) begin
         bemf_stopped <= 1'b0;
      end
   end

   // ************************************************************
   // divider and output pin
   // ************************************************************
   fgl_pulse_div u_div (
      .clk       (clk),
      .srst      (srst),
      .divider   (cfg.speed_pulse_divider),
      .pulse_in  (elec_pulse && pulse_gate),
      .pulse_out (divided_pulse)
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         speed_pulse_output <= 1'b0;
      end else if (cfg.speed_pulse_stop_policy) begin
         speed_pulse_output <= divided_pulse && !bemf_stopped;
      end else begin
         speed_pulse_output <= divided_pulse && motor_driven;
      end
   end

   // ************************************************************
   // early stop action
   // ************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         stop_hiz       <= 1'b0;
         stop_low_brake <= 1'b0;
      end else if (recirc_stop_req &&
                   (motor_phase == fgl_pkg::FGL_ALIGN || motor_phase == fgl_pkg::FGL_OPEN)) begin
         stop_hiz       <= !cfg.early_stop_brake_select;
         stop_low_brake <= cfg.early_stop_brake_select;
      end else begin
         stop_hiz       <= 1'b0;
         stop_low_brake <= 1'b0;
      end
   end

   // ************************************************************
   // axi write channel
   // ************************************************************
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;

   // byte-lane merge of write data
   always_comb begin
      next_cfg_word = loop_tuning_config_one;
      for (int i = 0; i < 4; i++) begin
         if (w_strb[i]) begin
            next_cfg_word[i*8 +: 8] = w_data[i*8 +: 8];
         end
      end
      next_cfg_word = next_cfg_word & fgl_pkg::LOOP_TUNING_MASK;
   end

   // capture address and data in either order, answer once both held
   always_ff @(posedge clk) begin
      if (srst) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= fgl_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == fgl_pkg::LOOP_TUNING_CONFIG_ONE_ADDR) ?
                            fgl_pkg::RESP_OKAY : fgl_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration register
   always_ff @(posedge clk) begin
      if (srst) begin
         loop_tuning_config_one <= fgl_pkg::LOOP_TUNING_RESET;
      end else if (aw_held && w_held && aw_addr == fgl_pkg::LOOP_TUNING_CONFIG_ONE_ADDR) begin
         loop_tuning_config_one <= next_cfg_word;
      end
   end

   // ************************************************************
   // axi read channel
   // ************************************************************
   assign s_axi_arready = !s_axi_rvalid;

   assign status_word = {24'h00_0000, bemf_stopped, pulse_gate, stop_low_brake, stop_hiz,
                         (cfg.back_emf_stop_threshold > fgl_pkg::BEMF_THR_MAX),
                         (cfg.speed_pulse_phase_select == 2'h3), motor_phase};

   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= fgl_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         case (s_axi_araddr)
            fgl_pkg::LOOP_TUNING_CONFIG_ONE_ADDR: begin
               s_axi_rdata <= loop_tuning_config_one;
               s_axi_rresp <= fgl_pkg::RESP_OKAY;
            end
            fgl_pkg::STATUS_ADDR: begin
               s_axi_rdata <= status_word;
               s_axi_rresp <= fgl_pkg::RESP_OKAY;
            end
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= fgl_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ==== fgl_loop_config_bench.sv ====
// bench: self-checking test of the loop configuration block
module fgl_loop_config_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk = 1'b0, srst = 1'b1;
   logic [7:0]          awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]         wdata = 32'h0;
   logic [3:0]          wstrb = 4'h0;
   logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic                awready, wready, bvalid, arready, rvalid, hiz, lowb, spo, elec;
   logic [1:0]          bresp, rresp, r;
   logic [31:0]         rdata, q, ex, d;
   logic [7:0]          bemf, thr_mv;
   fgl_pkg::fgl_phase_t phase = fgl_pkg::FGL_IDLE;
   fgl_pkg::fgl_cfg_t   cfg;
   logic                driven = 1'b0, first = 1'b0, stopreq = 1'b0, coast = 1'b0;
   logic [1:0]          gap = 2'h0;
   logic [3:0]          s;
   int                  miscompares = 0, n_checks = 0, k, ev, got, dv;
   // 50 MHz clock
   initial begin
      forever #10 clk = !clk;
   end
   fgl_loop_config DUT (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .motor_phase(phase),
      .motor_driven(driven), .first_try(first), .elec_pulse(elec), .bemf_mv(bemf), .recirc_stop_req(stopreq),
      .cfg(cfg), .bemf_thr_mv(thr_mv), .stop_hiz(hiz), .stop_low_brake(lowb), .speed_pulse_output(spo));
   fgl_motor_model eng (.clk(clk), .srst(srst), .gap(gap), .coast(coast), .elec_pulse(elec), .bemf_mv(bemf));
   // ******************************
   // helpers
   // ******************************
   // verdict and end of run
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one comparison
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // expected gate of the pulse output
   function automatic logic gate(input logic [1:0] sl, input logic [1:0] ph, input logic ft);
      case (sl)
         2'h0: return ph >= 2'h2;
         2'h1: return ph == 2'h3;
         2'h2: return ph == 2'h3 || ph == 2'h2 && ft;
         default: return 1'b0;
      endcase
   endfunction
   // byte merge of a write into the stored bits
   function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] st);
      for (int b = 0; b < 4; b++) begin
         if (st[b]) o[8*b+:8] = n[8*b+:8];
      end
      return o & fgl_pkg::LOOP_TUNING_MASK;
   endfunction
   // one bus transfer, a read when rd is set
   task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] dt, input logic [3:0] st);
      int  i;
      logic ta, tw, done;
      @(posedge clk);
      awaddr <= a;
      araddr <= a;
      wdata <= dt;
      wstrb <= st;
      arvalid <= rd;
      rready <= rd;
      awvalid <= !rd;
      wvalid <= !rd;
      bready <= !rd;
      for (i = 0; i < 40; i++) begin
         @(negedge clk);
         ta = arvalid && arready || awvalid && awready;
         tw = wvalid && wready;
         done = rd ? rvalid : bvalid;
         q = rdata;
         r = rd ? rresp : bresp;
         @(posedge clk);
         if (ta) begin
            arvalid <= 1'b0;
            awvalid <= 1'b0;
         end
         if (tw) wvalid <= 1'b0;
         if (done === 1'b1) break;
      end
      rready <= 1'b0;
      bready <= 1'b0;
      if (i == 40) begin
         chk("bus answer", 32'h1, 32'h0);
         wrap_up();
      end
   endtask
   // counts raw events and output pulses over one window
   task automatic window();
      ev = 0;
      got = 0;
      gap <= 2'($urandom);
      repeat (6) @(posedge clk);
      for (int i = 0; i < 202; i++) begin
         @(negedge clk);
         if (i < 200 && elec === 1'b1) ev++;
         if (i > 1 && spo === 1'b1) got++;
      end
   endtask
   // ******************************
   // main sequence
   // ******************************
   initial begin
      void'($urandom(32'h67b9bcd5));
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      xfer(1'b1, 8'h00, 32'h0, 4'h0);
      chk("config reset", fgl_pkg::LOOP_TUNING_RESET, q);
      xfer(1'b1, 8'h0c, 32'h0, 4'h0);
      chk("unmapped read", {30'h0, fgl_pkg::RESP_SLVERR}, {q[29:0], r});
      xfer(1'b0, 8'h10, 32'hffff_ffff, 4'hf);
      chk("unmapped write", fgl_pkg::RESP_SLVERR, r);
      ex = fgl_pkg::LOOP_TUNING_RESET;
      // strobed random writes, each read back
      for (k = 0; k < 10; k++) begin
         d = $urandom;
         s = k == 0 ? 4'h0 : k < 3 ? 4'hf : 4'($urandom);
         xfer(1'b0, fgl_pkg::LOOP_TUNING_CONFIG_ONE_ADDR, d, s);
         ex = mrg(ex, d, s);
         xfer(1'b1, fgl_pkg::LOOP_TUNING_CONFIG_ONE_ADDR, 32'h0, 4'h0);
         chk("read back", ex, q);
         chk("decoded fields", ex, {17'h0, cfg});
      end
      driven <= 1'b1;
      // every phase select code against every motor phase and try
      for (k = 0; k < 32; k++) begin
         phase <= fgl_pkg::fgl_phase_t'(k[1:0]);
         first <= k[2];
         xfer(1'b0, 8'h00, {18'h0, k[4:3], 12'h100}, 4'hf);
         window();
         chk("gated count", gate(k[4:3], k[1:0], k[2]) ? ev : 0, got);
      end
      phase <= fgl_pkg::FGL_CLOSED;
      // every divider code
      for (k = 0; k < 16; k++) begin
         xfer(1'b0, 8'h00, {20'h0, k[3:0], 8'h00}, 4'hf);
         window();
         dv = k < 2 ? 1 : k;
         chk("divided count", ev / dv + (got > ev / dv && ev % dv != 0), got);
      end
      // stop policies while the bridge is off
      driven <= 1'b0;
      xfer(1'b0, 8'h00, 32'h0000_0100, 4'hf);
      window();
      chk("pulses undriven", 32'h0, got);
      xfer(1'b0, 8'h00, 32'h0000_01d0, 4'hf);
      window();
      chk("pulses above bemf", ev, got);
      coast <= 1'b1;
      window();
      window();
      chk("pulses below bemf", 32'h0, got);
      // early stop action per phase, threshold codes alongside
      stopreq <= 1'b1;
      for (k = 0; k < 8; k++) begin
         phase <= fgl_pkg::fgl_phase_t'(k[1:0]);
         xfer(1'b0, 8'h00, {25'h0, k[2:0], 3'h0, k[2]}, 4'hf);
         repeat (2) @(negedge clk);
         chk("stop action", (k[1:0] == 2'h1 || k[1:0] == 2'h2) ? {k[2], !k[2]} : 2'h0, {lowb, hiz});
      end
      // live state word: closed loop, gate open, reserved threshold code flagged
      xfer(1'b1, fgl_pkg::STATUS_ADDR, 32'h0, 4'h0);
      chk("status word", 32'h0000_004b, q);
      wrap_up();
   end
endmodule

// ==== fgl_loop_config_chk.sv ====
// checker: port properties of the loop configuration block
module fgl_chk (
   // clock and reset
   input wire logic                clk,
   input wire logic                srst,
   // register bus
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic [7:0]          s_axi_araddr,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic [1:0]          s_axi_rresp,
   // engine side
   input wire fgl_pkg::fgl_phase_t motor_phase,
   input wire logic                recirc_stop_req,
   input wire logic                elec_pulse,
   input wire fgl_pkg::fgl_cfg_t   cfg,
   input wire logic [7:0]          bemf_thr_mv,
   input wire logic                stop_hiz,
   input wire logic                stop_low_brake,
   input wire logic                speed_pulse_output
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // threshold code to millivolts, reserved codes saturate
   function automatic logic [7:0] mv(input logic [2:0] c);
      logic [7:0] t [8] = '{8'h01, 8'h02, 8'h05, 8'h0a, 8'h14, 8'h1e, 8'h1e, 8'h1e};
      return t[c];
   endfunction
   logic [1:0] sel;    // phase select field
   logic       not_cl; // motor outside closed loop
   logic       early;  // stop request in align or open loop
   logic       rd_hs;  // read address taken
   assign sel = cfg.speed_pulse_phase_select;
   assign not_cl = motor_phase != fgl_pkg::FGL_CLOSED;
   assign early = recirc_stop_req && motor_phase inside {fgl_pkg::FGL_ALIGN, fgl_pkg::FGL_OPEN};
   assign rd_hs = s_axi_arvalid && s_axi_arready;
   cfg_stable_a: assert property (!$rose(s_axi_bvalid) |-> $stable(cfg))
      else $error("config changed without a write");
   thr_map_a: assert property (bemf_thr_mv == mv(cfg.back_emf_stop_threshold))
      else $error("threshold millivolts wrong");
   pulse_cause_a: assert property (speed_pulse_output |-> $past(elec_pulse, 2))
      else $error("pulse without raw event");
   closed_only_a: assert property (sel == 2'h1 && $past(sel, 2) == 2'h1 && not_cl && $past(not_cl)
         && $past(not_cl, 2) |-> !speed_pulse_output) else $error("pulse outside closed loop");
   brake_pick_a: assert property (early |=> stop_low_brake == $past(cfg.early_stop_brake_select)
         && stop_hiz == !stop_low_brake) else $error("early stop action wrong");
   brake_idle_a: assert property (!early |=> !stop_hiz && !stop_low_brake)
      else $error("stop action without request");
   read_back_a: assert property (rd_hs && s_axi_araddr == fgl_pkg::LOOP_TUNING_CONFIG_ONE_ADDR
         |=> s_axi_rdata == {17'h0, cfg} && s_axi_rresp == fgl_pkg::RESP_OKAY) else $error("read back wrong");
   read_err_a: assert property (rd_hs && s_axi_araddr > fgl_pkg::STATUS_ADDR
         |=> s_axi_rdata == 32'h0 && s_axi_rresp == fgl_pkg::RESP_SLVERR) else $error("unmapped read answered");
endmodule

bind fgl_loop_config fgl_chk chk_i (.clk(clk), .srst(srst), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .motor_phase(motor_phase),
   .recirc_stop_req(recirc_stop_req), .elec_pulse(elec_pulse), .cfg(cfg), .bemf_thr_mv(bemf_thr_mv),
   .stop_hiz(stop_hiz), .stop_low_brake(stop_low_brake), .speed_pulse_output(speed_pulse_output));

// ==== fgl_motor_model.sv ====
// far-side engine model: raw speed events and coasting back-emf
module fgl_motor_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // control
   input  wire logic [1:0] gap,
   input  wire logic       coast,
   // engine outputs
   output logic            elec_pulse,
   output logic [7:0]      bemf_mv
);
   logic [2:0] cnt;  // cycles since last event
   // one event every gap+2 cycles, prompt or slow rotation
   always_ff @(posedge clk) begin
      if (srst || cnt > {1'b0, gap}) begin
         cnt <= 3'h0;
      end else begin
         cnt <= cnt + 3'h1;
      end
      elec_pulse <= !srst && cnt > {1'b0, gap};
   end
   // back-emf held while powered, decays while coasting
   always_ff @(posedge clk) begin
      if (srst || !coast) begin
         bemf_mv <= 8'hc8;
      end else if (bemf_mv != 8'h00) begin
         bemf_mv <= bemf_mv - 8'h01;
      end
   end
endmodule

// ==== fgl_pkg.sv ====
// package: register map, field layout and encodings of the speed pulse / loop configuration block
package fgl_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0]  LOOP_TUNING_CONFIG_ONE_ADDR = 8'h00;  // config word
   localparam logic [7:0]  STATUS_ADDR                 = 8'h04;  // live state word
   localparam logic [31:0] LOOP_TUNING_RESET           = 32'h0000_0000;
   localparam logic [31:0] LOOP_TUNING_MASK            = 32'h0000_7fff; // bits 14..0 stored

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int MOD_SEL_POS     = 14;
   localparam int PHASE_SEL_LSB   = 12;
   localparam int DIVIDER_LSB     = 8;
   localparam int STOP_POLICY_POS = 7;
   localparam int BEMF_THR_LSB    = 4;
   localparam int SURGE_POS       = 3;
   localparam int DEADTIME_POS    = 2;
   localparam int VLOOP_OFF_POS   = 1;
   localparam int EARLY_BRAKE_POS = 0;

   // ************************************************************
   // axi responses
   // ************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************************
   // encodings
   // ************************************************************
   localparam logic [1:0] PHASE_ALWAYS    = 2'h0;
   localparam logic [1:0] PHASE_CLOSED    = 2'h1;
   localparam logic [1:0] PHASE_FIRST_TRY = 2'h2;
   localparam logic [2:0] BEMF_THR_MAX    = 3'h5;  // codes above are reserved

   // threshold codes 0..5 in millivolts
   localparam logic [7:0] BEMF_MV_0 = 8'h01;
   localparam logic [7:0] BEMF_MV_1 = 8'h02;
   localparam logic [7:0] BEMF_MV_2 = 8'h05;
   localparam logic [7:0] BEMF_MV_3 = 8'h0a;
   localparam logic [7:0] BEMF_MV_4 = 8'h14;
   localparam logic [7:0] BEMF_MV_5 = 8'h1e;

   // motor operating phase reported by the commutation engine
   typedef enum logic [1:0] {
      FGL_IDLE, FGL_ALIGN, FGL_OPEN, FGL_CLOSED
   } fgl_phase_t;

   // decoded configuration travelling together
   typedef struct packed {
      logic       discontinuous_svm;
      logic [1:0] speed_pulse_phase_select;
      logic [3:0] speed_pulse_divider;
      logic       speed_pulse_stop_policy;
      logic [2:0] back_emf_stop_threshold;
      logic       surge_guard_enable;
      logic       deadtime_comp_enable;
      logic       velocity_loop_off;
      logic       early_stop_brake_select;
   } fgl_cfg_t;

endpackage

// ==== fgl_pulse_div.sv ====
// speed pulse divider: passes one of every n electrical pulses
module fgl_pulse_div (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // control
   input  wire logic [3:0] divider,
   input  wire logic       pulse_in,
   // output
   output logic            pulse_out
);

   logic [3:0] count;  // pulses seen since last pass
   logic [3:0] limit;  // effective divide ratio

   // codes zero and one both divide by one
   assign limit = (divider == 4'h0) ? 4'h1 : divider;

   // ************************************************************
   // counter and registered output
   // ************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         count     <= 4'h0;
         pulse_out <= 1'b0;
      end else begin
         pulse_out <= 1'b0;
         if (pulse_in) begin
            if (count + 4'h1 >= limit) begin
               count     <= 4'h0;
               pulse_out <= 1'b1;
            end else begin
               count <= count + 4'h1;
            end
         end
      end
   end

endmodule
